//--- hw/mids_decode.sv
// combinational mode and pin function decode
`timescale 1ns/100ps
`default_nettype none
module mids_decode (
    // configuration fields
    input wire logic sensor_select_bit,
    input wire logic [1:0] tacho_edge_field,
    input wire logic [1:0] input_select_field,
    input wire logic comparator_off_bit,
    // decoded results
    output mids_pkg::mids_mode_e mode,
    output logic [5:0] pin_func,
    output logic rise_en,
    output logic fall_en,
    output logic cmp_on,
    output logic dedicated
);
    import mids_pkg::*;

    // function code for pin k; selected pin gets sel_code, others get rest_code
    function automatic logic [5:0] spread(input logic [1:0] sel, input logic [1:0] sel_code,
                                          input logic [1:0] rest_code);
        logic [5:0] r;
        r = {rest_code, rest_code, rest_code};
        if (sel == 2'h0) begin
            r[1:0] = sel_code;
        end else if (sel == 2'h1) begin
            r[3:2] = sel_code;
        end else if (sel == 2'h2) begin
            r[5:4] = sel_code;
        end
        return r;
    endfunction : spread

    // mode table, unlisted combinations fall to unused
    always_comb begin
        mode = MIDS_UNUSED;
        pin_func = {PIN_GPIO, PIN_GPIO, PIN_GPIO};
        rise_en = 1'b0;
        fall_en = 1'b0;
        cmp_on = 1'b0;
        dedicated = 1'b0;
        if (tacho_edge_field == 2'h0) begin
            if (input_select_field == 2'h3) begin
                mode = MIDS_UNUSED;
            end else if (comparator_off_bit) begin
                mode = MIDS_CMP_ANALOG;
                pin_func = spread(input_select_field, PIN_ANALOG, PIN_GPIO);
                cmp_on = 1'b1;
            end else if (sensor_select_bit) begin
                mode = MIDS_POSITION;
                pin_func = spread(input_select_field, PIN_DIGITAL, PIN_GPIO);
                rise_en = 1'b1;
                fall_en = 1'b1;
            end else begin
                mode = MIDS_SENSORLESS;
                pin_func = spread(input_select_field, PIN_ANALOG, PIN_OFF);
                cmp_on = 1'b1;
                dedicated = 1'b1;
            end
        end else if (input_select_field == 2'h3) begin
            if (comparator_off_bit) begin
                mode = MIDS_ALL_GPIO;
                cmp_on = 1'b0;
            end else begin
                mode = MIDS_ENCODER;
                pin_func = {PIN_GPIO, PIN_DIGITAL, PIN_DIGITAL};
                rise_en = 1'b1;
                fall_en = 1'b1;
            end
        end else begin
            mode = MIDS_TACHO;
            pin_func = spread(input_select_field, PIN_DIGITAL, PIN_GPIO);
            rise_en = tacho_edge_field[0];
            fall_en = tacho_edge_field[1];
        end
    end
endmodule : mids_decode
`default_nettype wire

//--- hw/mids_pkg.sv
// package for the motor input detection setup block: register map, fields, modes
package mids_pkg;
    // register byte offsets
    localparam logic [3:0] CFG_OFFS = 4'h0;
    localparam logic [3:0] STAT_OFFS = 4'h4;
    // configuration field positions
    localparam int SENSOR_SEL_POS = 0;
    localparam int TACHO_EDGE_LSB = 1;
    localparam int INPUT_SEL_LSB = 3;
    localparam int CMP_OFF_POS = 5;
    localparam int DISCHARGE_POS = 6;
    localparam int CFG_WIDTH = 7;
    localparam logic [6:0] CFG_RESET = 7'h00;
    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // pin function codes
    localparam logic [1:0] PIN_GPIO = 2'h0;
    localparam logic [1:0] PIN_ANALOG = 2'h1;
    localparam logic [1:0] PIN_DIGITAL = 2'h2;
    localparam logic [1:0] PIN_OFF = 2'h3;
    // detection modes
    typedef enum logic [2:0] {
        MIDS_UNUSED,
        MIDS_POSITION,
        MIDS_SENSORLESS,
        MIDS_TACHO,
        MIDS_ENCODER,
        MIDS_ALL_GPIO,
        MIDS_CMP_ANALOG
    } mids_mode_e;
endpackage : mids_pkg

//--- hw/mids_top.sv
// axi4-lite configured input detection setup for three motor input pins
`timescale 1ns/100ps
`default_nettype none
module mids_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pin setup towards the input stage, pin_func_q 2 bits per pin, first pin lowest
    output logic [5:0] pin_func_q,
    output logic [2:0] pin_alt_en_q,
    output logic [2:0] pin_ground_q,
    output logic edge_rise_en_q,
    output logic edge_fall_en_q,
    output logic comparator_on_q,
    output logic [2:0] mode_q
);
    import mids_pkg::*;

    // configuration word as last written
    logic [CFG_WIDTH-1:0] cfg_q;

    // write channel slots; address and data may arrive in either order
    logic [3:0] awaddr_q;
    logic aw_have_q;
    logic w_have_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    // decode results, one cycle ahead of the output flops
    mids_mode_e mode_d;
    logic [5:0] func_d;
    logic rise_d;
    logic fall_d;
    logic cmp_d;
    logic ded_d;

    // write strobe and per-pin enables derived from the pin functions
    logic do_write;
    logic [2:0] alt_d;
    logic [2:0] gnd_d;

    // the decode is purely combinational from the config word
    // every result is registered below before it leaves the block
    mids_decode u_decode (
        .sensor_select_bit(cfg_q[SENSOR_SEL_POS]),
        .tacho_edge_field(cfg_q[TACHO_EDGE_LSB +: 2]),
        .input_select_field(cfg_q[INPUT_SEL_LSB +: 2]),
        .comparator_off_bit(cfg_q[CMP_OFF_POS]),
        .mode(mode_d),
        .pin_func(func_d),
        .rise_en(rise_d),
        .fall_en(fall_d),
        .cmp_on(cmp_d),
        .dedicated(ded_d)
    );

    // write address and data are taken in either order, then answered together
    // holding off while bvalid stands keeps a second write from overrunning an unanswered one
    assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

    // write address slot, emptied when the write is carried out
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            awaddr_q <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_have_q <= 1'b0;
        end
    end

    // write data slot, emptied together with the address slot
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (do_write) begin
            w_have_q <= 1'b0;
        end
    end

    // ready only while the channel slot is empty
    // ready drops in the cycle a beat is taken, so a full slot never takes a second beat
    // trade-off: two idle cycles between writes, which a setup register can afford
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
        end
    end

    // config register; only byte lane 0 carries bits
    // no preload: a new word acts at once, so the select must stay put in comparator-off analog mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q <= CFG_RESET;
        end else if (do_write && awaddr_q[3:2] == CFG_OFFS[3:2] && wstrb_q[0]) begin
            cfg_q <= wdata_q[CFG_WIDTH-1:0];
        end
    end

    // write response; status is read only so a write there is an error
    // bvalid stands until bready is seen; bresp only changes with a new answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q[3:2] == CFG_OFFS[3:2]) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read channel, one outstanding read
    // status reads the output flops except pin_ground_q, so it shows the rest of what the input stage is really given
    // arready comes back only after the data beat has gone
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            if (s_axi_araddr[3:2] == CFG_OFFS[3:2]) begin
                s_axi_rdata <= {25'h0, cfg_q};
                s_axi_rresp <= RESP_OKAY;
            end else if (s_axi_araddr[3:2] == STAT_OFFS[3:2]) begin
                s_axi_rdata <= {16'h0, 1'b0, mode_q, comparator_on_q, edge_fall_en_q, edge_rise_en_q,
                                pin_alt_en_q, pin_func_q};
                s_axi_rresp <= RESP_OKAY;
            end else begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // alternate function held on every pin not plain gpio; grounding only for off pins
    // pins left to plain i/o never ground, whatever the discharge bit says
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            alt_d[k] = (func_d[2*k +: 2] != PIN_GPIO);
            gnd_d[k] = (func_d[2*k +: 2] == PIN_OFF) && ded_d && cfg_q[DISCHARGE_POS];
        end
    end

    // registered outputs lag the config by one cycle, harmless for slow setup
    // every output leaves from a flop so the input stage never sees decode glitches
    // all outputs change on the same edge, so mode and pin functions never disagree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_func_q <= 6'h0;
            pin_alt_en_q <= 3'h0;
            pin_ground_q <= 3'h0;
            edge_rise_en_q <= 1'b0;
            edge_fall_en_q <= 1'b0;
            comparator_on_q <= 1'b0;
            mode_q <= 3'h0;
        end else begin
            pin_func_q <= func_d;
            pin_alt_en_q <= alt_d;
            pin_ground_q <= gnd_d;
            edge_rise_en_q <= rise_d;
            edge_fall_en_q <= fall_d;
            comparator_on_q <= cmp_d;
            mode_q <= mode_d;
        end
    end
endmodule : mids_top
`default_nettype wire

//--- tb/mids_assertions.sv
// concurrent checks on the input detection setup outputs and write response
`timescale 1ns/100ps
`default_nettype none
module mids_assertions (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // pin setup outputs
    input wire logic [5:0] pin_func_q,
    input wire logic [2:0] pin_alt_en_q,
    input wire logic [2:0] pin_ground_q,
    input wire logic edge_rise_en_q,
    input wire logic edge_fall_en_q,
    input wire logic comparator_on_q,
    input wire logic [2:0] mode_q
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both halves of a write taken together, then the answer
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_resp_shown;
        ##[1:2] s_axi_bvalid;
    endsequence
    AST_WR_RESP: assert property (s_wr_taken |-> s_resp_shown) else $error("write answer missing");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    AST_POS_EDGES: assert property (mode_q == 3'h1 |-> edge_rise_en_q && edge_fall_en_q) else $error("pos edges");
    AST_SENSORLESS_PINS: assert property (mode_q == 3'h2 |-> pin_alt_en_q == 3'h7) else $error("pins free");
    AST_ENC: assert property (mode_q == 3'h4 |-> edge_rise_en_q && edge_fall_en_q && pin_func_q == 6'h0a) else $error("enc");
    AST_TACHO: assert property (mode_q == 3'h3 |-> $onehot(pin_alt_en_q) && (edge_rise_en_q || edge_fall_en_q)) else $error("tacho");
    AST_ALL_GPIO: assert property (mode_q == 3'h5 |-> !comparator_on_q && pin_func_q == 6'h00) else $error("all gpio");
    AST_CMP_ANALOG: assert property (mode_q == 3'h6 |-> comparator_on_q && $onehot(pin_alt_en_q)) else $error("cmp analog");
    AST_GROUND: assert property (pin_ground_q != 3'h0 |-> mode_q == 3'h2) else $error("ground outside sensorless");
    AST_ALT_FUNC: assert property (pin_alt_en_q == {|pin_func_q[5:4], |pin_func_q[3:2], |pin_func_q[1:0]})
        else $error("alt enable mismatch");
endmodule : mids_assertions
bind mids_top mids_assertions chk_u (.*);
`default_nettype wire

//--- tb/mids_motor_model.sv
// far-side model: motor windings whose level a grounded pin pulls low
`timescale 1ns/100ps
`default_nettype none
module mids_motor_model (
    // clock
    input wire logic aclk,
    // device grounding and sensed level
    input wire logic [2:0] pin_ground_q,
    output logic [2:0] pin_level
);
    logic [2:0] winding_q = 3'h5;
    // windings swing every cycle so a stale level never passes for a driven one
    always @(posedge aclk) begin
        winding_q <= ~winding_q;
    end
    // grounded pin reads low, a high-impedance pin follows its winding
    assign pin_level = winding_q & ~pin_ground_q;
endmodule : mids_motor_model
`default_nettype wire

//--- tb/mids_top_tb.sv
// self-checking bench for the input detection setup block
`timescale 1ns/100ps
`default_nettype none
module mids_top_tb;
    import mids_pkg::*;
    `define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [5:0] pin_func_q;
    logic [2:0] pin_alt_en_q, pin_ground_q, mode_q, pin_level;
    logic edge_rise_en_q, edge_fall_en_q, comparator_on_q;
    int failures = 0, n_checks = 0;
    initial forever #12.5 aclk = ~aclk;
    mids_top dut_u (.*);
    mids_motor_model model_u (.*);
    task automatic give_verdict();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    // bounded wait: a hung handshake ends the run
    task automatic guard(inout int n);
        n++;
        if (n > 50) begin failures++; give_verdict(); end
    endtask : guard
    task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] st, output logic [1:0] rsp);
        int n = 0;
        s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            guard(n);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        repeat (2) @(posedge aclk); // outputs settle one edge after the answer
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rsp);
        int n = 0;
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            guard(n);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata; rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    // expected decode of one configuration word
    task automatic expect_cfg(input logic [6:0] c);
        logic [2:0] m;
        logic [5:0] f;
        logic [1:0] on, off;
        logic [2:0] alt;
        m = c[2:1] == 0 ? (c[4:3] == 3 ? 3'h0 : c[5] ? 3'h6 : c[0] ? 3'h1 : 3'h2) : (c[4:3] != 3 ? 3'h3 : c[5] ? 3'h5 : 3'h4);
        on = (m == 2 || m == 6) ? PIN_ANALOG : PIN_DIGITAL;
        off = m == 2 ? PIN_OFF : PIN_GPIO;
        for (int k = 0; k < 3; k++) f[2*k +: 2] = (k == c[4:3]) ? on : off;
        if (m == 4) f = 6'h0a;
        if (m == 5 || m == 0) f = 6'h00;
        for (int k = 0; k < 3; k++) alt[k] = (f[2*k +: 2] != PIN_GPIO);
        `CHK(mode_q, m)
        `CHK(pin_func_q, f)
        `CHK(pin_alt_en_q, alt)
        `CHK(pin_ground_q, (m == 2 && c[6]) ? ~(3'h1 << c[4:3]) : 3'h0)
        `CHK({edge_fall_en_q, edge_rise_en_q}, m == 3 ? c[2:1] : (m == 1 || m == 4) ? 2'h3 : 2'h0)
        if (m == 2 || m == 5 || m == 6) `CHK(comparator_on_q, m != 5)
    endtask : expect_cfg
    task automatic test_reset();
        expect_cfg(CFG_RESET);
        rd(CFG_OFFS, d, r);
        `CHK({d, r}, {32'h0, RESP_OKAY})
        $display("reset test done");
    endtask : test_reset
    // select changes only after a word with a nonzero edge field
    task automatic test_sweep();
        logic [6:0] c;
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 32; j++) begin
                c = {j[4:3], i[1:0], j[2:0]};
                wr(CFG_OFFS, {25'h0, c}, 4'hf, r);
                `CHK(r, RESP_OKAY)
                expect_cfg(c);
            end
        end
        $display("sweep test done");
    endtask : test_sweep
    task automatic test_refused();
        wr(CFG_OFFS, 32'h3a, 4'hf, r);
        wr(STAT_OFFS, 32'h0, 4'hf, r);
        `CHK(r, RESP_SLVERR)
        wr(4'h8, 32'h0, 4'hf, r);
        `CHK(r, RESP_SLVERR)
        wr(CFG_OFFS, 32'h0, 4'he, r);
        expect_cfg(7'h3a);
        rd(STAT_OFFS, d, r);
        `CHK(d[14:11], 4'ha)
        rd(4'h8, d, r);
        `CHK({d, r}, {32'h0, RESP_SLVERR})
        $display("refused test done");
    endtask : test_refused
    task automatic test_discharge();
        logic [2:0] a;
        wr(CFG_OFFS, 32'h48, 4'hf, r);
        a = pin_level;
        @(posedge aclk);
        `CHK({a, pin_level} & 6'h2d, 6'h00)
        wr(CFG_OFFS, 32'h08, 4'hf, r);
        a = pin_level;
        @(posedge aclk);
        `CHK(a[0] ^ pin_level[0], 1'b1)
        $display("discharge test done");
    endtask : test_discharge
    // answer held back by the master: bvalid must stand until bready is seen
    task automatic test_slow_resp();
        int n = 0;
        s_axi_awaddr <= CFG_OFFS; s_axi_wdata <= 32'h0; s_axi_wstrb <= 4'h1;
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            guard(n);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        repeat (3) @(posedge aclk);
        `CHK(s_axi_bvalid, 1'b1)
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        `CHK(s_axi_bresp, RESP_OKAY)
        s_axi_bready <= 1'b0;
        @(posedge aclk);
        `CHK(s_axi_bvalid, 1'b0)
        expect_cfg(7'h00);
        $display("slow response test done");
    endtask : test_slow_resp
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        test_reset();
        test_sweep();
        test_refused();
        test_discharge();
        test_slow_resp();
        give_verdict();
    end
endmodule : mids_top_tb
`default_nettype wire
